/* File: voltage_preset_ramp_control_tb.sv */
// Self-checking bench for the preset and ramp setpoint controller
`timescale 1ns/1ps
`include "vprc_defines.svh"
module voltage_preset_ramp_control_tb;
	import vprc_pkg::*;
	localparam int CYCLE_LIMIT = 20000; // Run ceiling in cycles
	// One register access with its expected answer
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wd;
		logic [31:0] rd;
		logic        err;
	} vprc_row_t;
	logic        clock_i   = 1'b0;  // Bench clock
	logic        rst_n_i   = 1'b0;  // Reset, active low
	logic        psel_i    = 1'b0;  // APB request
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [7:0]  paddr_i   = 8'h00;
	logic [31:0] pwdata_i  = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic [1:0]  sel_req   = 2'h0;  // Preset asked of the host model
	logic        sel_lsb;           // Select pins
	logic        sel_msb;
	logic [6:0]  setpoint_code_o;
	logic [10:0] setpoint_mv_o;
	logic [1:0]  active_preset_o;
	logic        forced_pwm_o;
	logic        pfm_ok_o;          // Light-load pulse mode allowed
	logic        ramp_busy_o;
	logic [6:0]  code_w;            // Seven-bit variant setpoint
	logic [10:0] mv_w;              // Seven-bit variant millivolts
	int          w_steps;           // Seven-bit setpoint changes in a wait
	int          err_count = 0;     // Mismatches
	int          n_tests   = 0;     // Comparisons
	int          cyc_count = 0;     // Cycles run
	int          n;                 // Measured cycles
	logic [31:0] rd;
	logic        er;
	// Reset reads, refusals, field masks
	vprc_row_t   rows [13] = '{
		'{1'b0, 8'h00, 32'h0, 32'h3f, 1'b0},
		'{1'b0, 8'h04, 32'h0, 32'h17, 1'b0},
		'{1'b0, 8'h08, 32'h0, 32'h3f, 1'b0},
		'{1'b0, 8'h0c, 32'h0, 32'h21, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h00, 1'b0},
		'{1'b1, 8'h18, 32'h5, 32'h00, 1'b1},
		'{1'b0, 8'h18, 32'h0, 32'h00, 1'b1},
		'{1'b1, 8'h01, 32'h5, 32'h00, 1'b1},
		'{1'b1, 8'h14, 32'h5, 32'h00, 1'b1},
		'{1'b1, 8'h08, 32'hff, 32'h00, 1'b0},
		'{1'b0, 8'h08, 32'h0, 32'hbf, 1'b0},
		'{1'b1, 8'h10, 32'hff, 32'h00, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h0f, 1'b0}
	};

	// Free-running clock, 40 ns period
	always #20 clock_i = ~clock_i;

	// Host model on the select pins
	vprc_host_pins host (
		.clock_i             (clock_i),
		.preset_req_i        (sel_req),
		.preset_select_lsb_o (sel_lsb),
		.preset_select_msb_o (sel_msb)
	);

	// Six-bit variant under test
	vprc_ramp_ctrl #(.WIDE_VARIANT(1'b0)) uut (
		.clock_i                             (clock_i),
		.rst_n_i                             (rst_n_i),
		.psel_i                              (psel_i),
		.penable_i                           (penable_i),
		.pwrite_i                            (pwrite_i),
		.paddr_i                             (paddr_i),
		.pwdata_i                            (pwdata_i),
		.prdata_o                            (prdata_o),
		.pready_o                            (pready_o),
		.pslverr_o                           (pslverr_o),
		.preset_select_lsb_i                 (sel_lsb),
		.preset_select_msb_i                 (sel_msb),
		.setpoint_code_o                     (setpoint_code_o),
		.setpoint_mv_o                       (setpoint_mv_o),
		.active_preset_o                     (active_preset_o),
		.forced_pwm_o                        (forced_pwm_o),
		.pulse_frequency_operation_allowed_o (pfm_ok_o),
		.ramp_busy_o                         (ramp_busy_o)
	);

	// Seven-bit variant on the same bus and pins
	vprc_ramp_ctrl #(.WIDE_VARIANT(1'b1)) uut_wide (
		.clock_i                             (clock_i),
		.rst_n_i                             (rst_n_i),
		.psel_i                              (psel_i),
		.penable_i                           (penable_i),
		.pwrite_i                            (pwrite_i),
		.paddr_i                             (paddr_i),
		.pwdata_i                            (pwdata_i),
		.prdata_o                            (),
		.pready_o                            (),
		.pslverr_o                           (),
		.preset_select_lsb_i                 (sel_lsb),
		.preset_select_msb_i                 (sel_msb),
		.setpoint_code_o                     (code_w),
		.setpoint_mv_o                       (mv_w),
		.active_preset_o                     (),
		.forced_pwm_o                        (),
		.pulse_frequency_operation_allowed_o (),
		.ramp_busy_o                         ()
	);

	// Counts, verdict, end of run
	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Value compare with case equality
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// Cycle count must fall in a window
	task automatic rng(input string name, input int lo, input int hi, input int got);
		n_tests++;
		if (got < lo || got > hi) begin
			$display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
			err_count++;
		end
	endtask

	// APB transfer; ready, read data and error taken at one rising edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rdat, output logic err);
		int w;
		@(posedge clock_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= addr;
		pwdata_i <= wd;
		@(posedge clock_i);
		penable_i <= 1'b1;
		w = 0;
		@(posedge clock_i);
		while (pready_o !== 1'b1 && w < 20) begin
			@(posedge clock_i);
			w++;
		end
		rng("apb wait", 0, 19, w);
		rdat = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Wait for a setpoint code; in a ramp each step moves one code
	task automatic wait_code(input logic [6:0] exp, input logic ramp, output int cnt);
		logic [6:0] last;
		logic [6:0] last_w;
		last = setpoint_code_o;
		last_w = code_w;
		cnt = 0;
		w_steps = 0;
		while (setpoint_code_o !== exp && cnt < 3000) begin
			@(negedge clock_i);
			cnt++;
			if (ramp && setpoint_code_o !== last)
				chk("step", 32'h1, 32'((setpoint_code_o > last) ? setpoint_code_o - last : last - setpoint_code_o));
			if (code_w !== last_w)
				w_steps++;
			last = setpoint_code_o;
			last_w = code_w;
		end
	endtask

	// Hang guard
	always @(posedge clock_i) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == CYCLE_LIMIT) begin
			err_count++;
			test_done();
		end
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		// Table of register accesses
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].addr, rows[i].wd, rd, er);
			if (!rows[i].wr)
				chk("read data", rows[i].rd, rd);
			chk("slave error", 32'(rows[i].err), 32'(er));
		end
		// Preset zero after reset, mapped at 10 mV per code
		chk("setpoint", 32'h3f, 32'(setpoint_code_o));
		chk("setpoint mv", 32'd1400, 32'(setpoint_mv_o));
		chk("pfm allowed", 32'h1, 32'(pfm_ok_o));
		chk("wide mv", 32'd1130, 32'(mv_w));
		apb(1'b1, 8'h10, 32'h0, rd, er);
		// Power-save fall with light-load ramp off jumps
		@(posedge clock_i);
		sel_req <= 2'h1;
		wait_code(7'h17, 1'b0, n);
		rng("jump down", 0, 5, n);
		chk("active preset", 32'h1, 32'(active_preset_o));
		// Millivolt output lags the code by one cycle
		@(negedge clock_i);
		chk("setpoint mv", 32'd1000, 32'(setpoint_mv_o));
		// Power-save rise ramps, 10 steps at code 0
		@(posedge clock_i);
		sel_req <= 2'h3;
		wait_code(7'h21, 1'b1, n);
		rng("rise code 0", 76, 90, n);
		rng("wide steps", 5, 5, w_steps);
		chk("wide code", 32'h21, 32'(code_w));
		// Rewrite of active preset ramps after the write, code 2
		apb(1'b1, 8'h10, 32'h2, rd, er);
		apb(1'b1, 8'h0c, 32'h25, rd, er);
		wait_code(7'h25, 1'b1, n);
		rng("rise code 2", 122, 132, n);
		rng("wide steps", 2, 2, w_steps);
		// Slowest code, one step
		apb(1'b1, 8'h10, 32'h7, rd, er);
		apb(1'b1, 8'h0c, 32'h26, rd, er);
		repeat (4) @(negedge clock_i);
		chk("ramp busy", 32'h1, 32'(ramp_busy_o));
		wait_code(7'h26, 1'b1, n);
		rng("rise code 7", 996, 1008, n);
		chk("wide code", 32'h26, 32'(code_w));
		// Same rate on another preset, 25 steps at code 1
		apb(1'b1, 8'h10, 32'h1, rd, er);
		@(posedge clock_i);
		sel_req <= 2'h2;
		wait_code(7'h3f, 1'b1, n);
		rng("shared rate", 386, 400, n);
		chk("forced pwm", 32'h1, 32'(forced_pwm_o));
		chk("pfm allowed", 32'h0, 32'(pfm_ok_o));
		// Forced PWM fall ramps
		apb(1'b1, 8'h08, 32'hbb, rd, er);
		wait_code(7'h3b, 1'b1, n);
		rng("forced fall", 58, 70, n);
		// Mode change in the active preset
		apb(1'b1, 8'h08, 32'h3b, rd, er);
		repeat (3) @(negedge clock_i);
		chk("forced pwm", 32'h0, 32'(forced_pwm_o));
		// Power-save fall with light-load ramp on, then a jump with it off
		apb(1'b1, 8'h10, 32'h9, rd, er);
		apb(1'b1, 8'h08, 32'h37, rd, er);
		wait_code(7'h37, 1'b1, n);
		rng("light fall", 58, 70, n);
		apb(1'b1, 8'h10, 32'h1, rd, er);
		apb(1'b1, 8'h08, 32'h33, rd, er);
		wait_code(7'h33, 1'b0, n);
		rng("jump down", 0, 5, n);
		// Status: setpoint, preset two, settled, power-save
		repeat (3) @(negedge clock_i);
		apb(1'b0, 8'h14, 32'h0, rd, er);
		chk("status", 32'h133, rd);
		chk("ramp busy", 32'h0, 32'(ramp_busy_o));
		// Second reset in mid-run
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		@(negedge clock_i);
		chk("reset setpoint", 32'h0, 32'(setpoint_code_o));
		chk("reset pfm", 32'h1, 32'(pfm_ok_o));
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		apb(1'b0, 8'h08, 32'h0, rd, er);
		chk("preset two", 32'h3f, rd);
		chk("setpoint", 32'h3f, 32'(setpoint_code_o));
		test_done();
	end
endmodule

/* File: vprc_defines.svh */
// Constants for the preset and ramp setpoint controller
//
// Functional notes
// - Four presets; select pins pick applied one.
// - Code is linear, 10 mV per step.
// - Active preset rewrite starts move after write.
// - One ramp rate shared by all presets.
// - Bit 7 picks power-save or forced PWM.
// - Mode change in active preset applies directly.
// - Ramp code 000 is 32 mV/us, halving.
// - Steps 10 mV, or 20 mV plus 10.
// - Forced PWM ramps both directions at slope.
// - Power-save still ramps upward at slope.
// - Light-load enable bit controls downward slope.
// - Forced PWM stays fixed-frequency at light load.
// - Select pins 00 to 11 pick presets 0-3.
// - Reset presets are power-save, factory codes.
`ifndef VPRC_DEFINES_SVH
`define VPRC_DEFINES_SVH

// Register indices; byte address is four times the index
`define VPRC_IDX_PRESET_ZERO  4'h0
`define VPRC_IDX_PRESET_ONE   4'h1
`define VPRC_IDX_PRESET_TWO   4'h2
`define VPRC_IDX_PRESET_THREE 4'h3
`define VPRC_IDX_CTRL         4'h4
`define VPRC_IDX_STATUS       4'h5

// Preset register fields
`define VPRC_MODE_BIT         7
`define VPRC_CODE_MSB         6
`define VPRC_MASK_NARROW      7'h3f
`define VPRC_MASK_WIDE        7'h7f

// Control register fields
`define VPRC_CTRL_RATE_MSB    2
`define VPRC_CTRL_LIGHT_BIT   3
`define VPRC_CTRL_RESET       4'h0

// Status register fields
`define VPRC_STAT_PRESET_LSB  7
`define VPRC_STAT_BUSY_BIT    9
`define VPRC_STAT_FPWM_BIT    10

// Factory presets, all power-save
`define VPRC_RST_PRESET_ZERO  8'h3f
`define VPRC_RST_PRESET_ONE   8'h17
`define VPRC_RST_PRESET_TWO   8'h3f
`define VPRC_RST_PRESET_THREE 8'h21

// Voltage mapping
`define VPRC_LSB_MV           10
`define VPRC_BASE_NARROW_MV   770
`define VPRC_BASE_WIDE_MV     500

// Ramp timing
`define VPRC_CLK_PERIOD_NS    40
`define VPRC_RATE_FAST_MV_US  32
`define VPRC_ACC_UNIT_UV      10
`define VPRC_RATE_INC_FAST    ((`VPRC_RATE_FAST_MV_US * `VPRC_CLK_PERIOD_NS) / `VPRC_ACC_UNIT_UV)
`define VPRC_STEP_SMALL_MV    10
`define VPRC_STEP_BIG_MV      20
`define VPRC_THR_SMALL        ((`VPRC_STEP_SMALL_MV * 1000) / `VPRC_ACC_UNIT_UV)
`define VPRC_THR_BIG          ((`VPRC_STEP_BIG_MV * 1000) / `VPRC_ACC_UNIT_UV)

`endif

/* File: vprc_host_pins.sv */
// Host model that drives the two preset select pins
`timescale 1ns/1ps
module vprc_host_pins (
	input  wire logic       clock_i,
	input  wire logic [1:0] preset_req_i,        // Preset the host wants
	output logic            preset_select_lsb_o, // Select pin bit 0
	output logic            preset_select_msb_o  // Select pin bit 1
);
	// Pins start low, choosing preset zero
	initial begin
		preset_select_lsb_o = 1'b0;
		preset_select_msb_o = 1'b0;
	end
	// pin pair value
	// Pins change just after a rising edge
	always @(posedge clock_i) begin
		preset_select_lsb_o <= preset_req_i[0];
		preset_select_msb_o <= preset_req_i[1];
	end
endmodule

/* File: vprc_pkg.sv */
// Types for the preset and ramp setpoint controller
package vprc_pkg;

	// Ramp progress of the setpoint
	typedef enum logic [1:0] {
		VPRC_SETTLED,
		VPRC_RISING,
		VPRC_FALLING
	} vprc_ramp_state_t;

endpackage

/* File: vprc_preset_reg.sv */
// One preset register with its own reset value
`timescale 1ns/1ps
`include "vprc_defines.svh"
module vprc_preset_reg
	import vprc_pkg::*;
#(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] value_o
);

	// Stored preset, mode bit on top
	logic [7:0] value_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_q <= RESET_VAL;
		end else if (we_i) begin
			value_q <= wdata_i;
		end
	end

	assign value_o = value_q;

endmodule

/* File: vprc_ramp_ctrl.sv */
// Preset registers, APB slave and setpoint ramp control
`timescale 1ns/1ps
`include "vprc_defines.svh"
module vprc_ramp_ctrl
	import vprc_pkg::*;
#(
	parameter bit WIDE_VARIANT = 1'b0 // Seven-bit code variant
) (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Preset select pins
	input  wire logic        preset_select_lsb_i,
	input  wire logic        preset_select_msb_i,
	// Converter control
	output logic      [6:0]  setpoint_code_o,
	output logic      [10:0] setpoint_mv_o,
	output logic      [1:0]  active_preset_o,
	output logic             forced_pwm_o,
	output logic             pulse_frequency_operation_allowed_o,
	output logic             ramp_busy_o
);

	// Mask of valid code bits for this variant
	localparam logic [6:0]  CODE_MASK = WIDE_VARIANT ? `VPRC_MASK_WIDE : `VPRC_MASK_NARROW;
	localparam logic [10:0] BASE_MV   = WIDE_VARIANT ? 11'(`VPRC_BASE_WIDE_MV)
	                                                 : 11'(`VPRC_BASE_NARROW_MV);
	localparam logic [3:0]  LSB_MV    = 4'(`VPRC_LSB_MV);

	// Bus decode
	logic        setup_phase;  // First cycle of a transfer
	logic        wr_fire;      // Write taking effect this edge
	logic [3:0]  reg_idx;      // Word index of the address
	logic        addr_ok;      // Address maps to a register
	logic        addr_aligned; // Low two and top two address bits clear

	// Register file
	logic [7:0]  preset_val [4]; // Four preset words
	logic [3:0]  preset_we;      // Per-preset write strobe
	logic [7:0]  preset_wdata;   // Masked write data
	logic [3:0]  ctrl_q;         // Ramp code and light-load bit
	logic [2:0]  ramp_rate_code; // Shared ramp code
	logic        ramp_in_light_load_enable;

	// Bus answer flops
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] rd_word;        // Read mux

	// Preset selection
	logic [1:0]  sel_idx;        // Pins as an index
	logic [7:0]  sel_val;        // Selected preset word
	logic [6:0]  target_code;    // Code the setpoint heads for
	logic        target_fpwm;    // Selected mode bit

	// Ramp state
	vprc_ramp_state_t state_q;
	logic [6:0]  setpoint_q;     // Current setpoint code
	logic        init_done_q;    // Setpoint loaded after reset
	logic [6:0]  diff_up;        // Codes to go upward
	logic [6:0]  diff_dn;        // Codes to go downward
	logic        moving_up;
	logic        moving_dn;
	logic        down_controlled; // Downward slope enforced
	logic        big_step;        // Next step is 20 mV
	logic        step_pulse;      // From step timer
	logic        timer_run;

	// Output flops
	logic [1:0]  active_preset_q;
	logic        forced_pwm_q;
	logic        light_allowed_q;
	logic        ramp_busy_q;
	logic [10:0] setpoint_mv_q;

	// Transfer phases
	assign setup_phase  = psel_i && !penable_i;
	assign wr_fire      = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
	assign reg_idx      = paddr_i[5:2];
	assign addr_aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[7:6] == 2'b00);
	assign addr_ok      = addr_aligned && (reg_idx <= `VPRC_IDX_STATUS);

	// code bits beyond the variant read zero
	assign preset_wdata = {pwdata_i[`VPRC_MODE_BIT], pwdata_i[`VPRC_CODE_MSB:0] & CODE_MASK};

	// Per-preset write strobes
	always_comb begin
		preset_we = 4'h0;
		if (wr_fire && reg_idx <= `VPRC_IDX_PRESET_THREE) begin
			preset_we[reg_idx[1:0]] = 1'b1;
		end
	end

	vprc_preset_reg #(.RESET_VAL(`VPRC_RST_PRESET_ZERO)) u_preset_zero (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.we_i    (preset_we[0]),
		.wdata_i (preset_wdata),
		.value_o (preset_val[0])
	);
	vprc_preset_reg #(.RESET_VAL(`VPRC_RST_PRESET_ONE)) u_preset_one (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.we_i    (preset_we[1]),
		.wdata_i (preset_wdata),
		.value_o (preset_val[1])
	);
	vprc_preset_reg #(.RESET_VAL(`VPRC_RST_PRESET_TWO)) u_preset_two (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.we_i    (preset_we[2]),
		.wdata_i (preset_wdata),
		.value_o (preset_val[2])
	);
	vprc_preset_reg #(.RESET_VAL(`VPRC_RST_PRESET_THREE)) u_preset_three (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.we_i    (preset_we[3]),
		.wdata_i (preset_wdata),
		.value_o (preset_val[3])
	);

	// one ramp setting for all presets
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `VPRC_CTRL_RESET;
		end else if (wr_fire && reg_idx == `VPRC_IDX_CTRL) begin
			ctrl_q <= pwdata_i[3:0];
		end
	end

	assign ramp_rate_code            = ctrl_q[`VPRC_CTRL_RATE_MSB:0];
	assign ramp_in_light_load_enable = ctrl_q[`VPRC_CTRL_LIGHT_BIT];

	// Read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		case (reg_idx)
			`VPRC_IDX_PRESET_ZERO:  rd_word[7:0] = preset_val[0];
			`VPRC_IDX_PRESET_ONE:   rd_word[7:0] = preset_val[1];
			`VPRC_IDX_PRESET_TWO:   rd_word[7:0] = preset_val[2];
			`VPRC_IDX_PRESET_THREE: rd_word[7:0] = preset_val[3];
			`VPRC_IDX_CTRL:         rd_word[3:0] = ctrl_q;
			`VPRC_IDX_STATUS: begin
				rd_word[6:0]                          = setpoint_q;
				rd_word[`VPRC_STAT_PRESET_LSB +: 2]   = active_preset_q;
				rd_word[`VPRC_STAT_BUSY_BIT]          = ramp_busy_q;
				rd_word[`VPRC_STAT_FPWM_BIT]          = forced_pwm_q;
			end
			default:                rd_word = 32'h0000_0000;
		endcase
	end

	// Answer flops: ready in the first access cycle
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (setup_phase) begin
			// Unmapped, misaligned or status write is refused
			pready_q  <= 1'b1;
			pslverr_q <= !addr_ok || (pwrite_i && reg_idx == `VPRC_IDX_STATUS);
			prdata_q  <= (!pwrite_i && addr_ok) ? rd_word : 32'h0000_0000;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	assign sel_idx     = {preset_select_msb_i, preset_select_lsb_i};
	assign sel_val     = preset_val[sel_idx];
	// rewritten active code becomes target at once
	assign target_code = sel_val[`VPRC_CODE_MSB:0] & CODE_MASK;
	assign target_fpwm = sel_val[`VPRC_MODE_BIT];

	// Distance to the target
	assign moving_up = target_code > setpoint_q;
	assign moving_dn = target_code < setpoint_q;
	assign diff_up   = target_code - setpoint_q;
	assign diff_dn   = setpoint_q - target_code;

	assign down_controlled = target_fpwm || ramp_in_light_load_enable;

	// Seven-bit variant only: 20 mV steps while two codes remain
	assign big_step  = WIDE_VARIANT && (moving_up ? (diff_up >= 7'h02) : (diff_dn >= 7'h02));
	assign timer_run = init_done_q && (moving_up || (moving_dn && down_controlled));

	vprc_step_timer u_step_timer (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.run_i       (timer_run),
		.big_step_i  (big_step),
		.rate_code_i (ramp_rate_code),
		.step_o      (step_pulse)
	);

	// Setpoint stepping toward the target
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			setpoint_q  <= 7'h00;
			init_done_q <= 1'b0;
			state_q     <= VPRC_SETTLED;
		end else if (!init_done_q) begin
			// Take the selected preset after reset release
			setpoint_q  <= target_code;
			init_done_q <= 1'b1;
			state_q     <= VPRC_SETTLED;
		end else begin
			case (state_q)
				VPRC_SETTLED: begin
					if (moving_up) begin
						state_q <= VPRC_RISING;
					end else if (moving_dn && down_controlled) begin
						state_q <= VPRC_FALLING;
					end else if (moving_dn) begin
						setpoint_q <= target_code;
					end
				end
				VPRC_RISING: begin
					if (!moving_up) begin
						state_q <= VPRC_SETTLED;
					end else if (step_pulse) begin
						// double step or single final step
						setpoint_q <= (WIDE_VARIANT && diff_up >= 7'h02) ? setpoint_q + 7'h02
						                                                : setpoint_q + 7'h01;
					end
				end
				VPRC_FALLING: begin
					if (!moving_dn || !down_controlled) begin
						state_q <= VPRC_SETTLED;
					end else if (step_pulse) begin
						setpoint_q <= (WIDE_VARIANT && diff_dn >= 7'h02) ? setpoint_q - 7'h02
						                                                : setpoint_q - 7'h01;
					end
				end
				default: begin
					state_q <= VPRC_SETTLED;
				end
			endcase
		end
	end

	// Registered converter outputs
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_preset_q <= 2'b00;
			forced_pwm_q    <= 1'b0;
			light_allowed_q <= 1'b1;
			ramp_busy_q     <= 1'b0;
			setpoint_mv_q   <= 11'h000;
		end else begin
			active_preset_q <= sel_idx;
			forced_pwm_q    <= target_fpwm;
			light_allowed_q <= !target_fpwm;
			ramp_busy_q     <= state_q != VPRC_SETTLED;
			// base plus 10 mV per code
			setpoint_mv_q   <= BASE_MV + 11'(setpoint_q * LSB_MV);
		end
	end

	assign prdata_o                            = prdata_q;
	assign pready_o                            = pready_q;
	assign pslverr_o                           = pslverr_q;
	assign setpoint_code_o                     = setpoint_q;
	assign setpoint_mv_o                       = setpoint_mv_q;
	assign active_preset_o                     = active_preset_q;
	assign forced_pwm_o                        = forced_pwm_q;
	assign pulse_frequency_operation_allowed_o = light_allowed_q;
	assign ramp_busy_o                         = ramp_busy_q;

	// Active preset index tracks the pins
	AST_SEL_MAP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$past(rst_n_i) |-> active_preset_o == $past(sel_idx))
		else $error("active preset not taken from pins");

	// Mode output follows the selected preset bit
	AST_MODE_FOLLOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$past(rst_n_i) |-> forced_pwm_o == $past(target_fpwm))
		else $error("mode bit not applied");

	// Light-load operation only outside forced PWM
	AST_LIGHT_LOAD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		##1 pulse_frequency_operation_allowed_o != forced_pwm_o)
		else $error("light-load permission wrong");

	// Upward moves only on a timer step and by one step
	AST_UP_STEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(init_done_q && $past(init_done_q) && setpoint_q > $past(setpoint_q))
		|-> ($past(step_pulse) && (setpoint_q - $past(setpoint_q)) <= (WIDE_VARIANT ? 7'h02 : 7'h01)))
		else $error("setpoint rose without a timed step");

	// Forced PWM falls step by step
	AST_DOWN_FPWM: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(init_done_q && $past(init_done_q) && $past(target_fpwm) && setpoint_q < $past(setpoint_q))
		|-> ($past(step_pulse) && ($past(setpoint_q) - setpoint_q) <= (WIDE_VARIANT ? 7'h02 : 7'h01)))
		else $error("forced PWM fall not stepped");

	// Uncontrolled fall reaches the target next cycle
	AST_DOWN_FREE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(init_done_q && state_q == VPRC_SETTLED && moving_dn && !down_controlled)
		|=> setpoint_q == $past(target_code))
		else $error("uncontrolled fall did not land");

	// Write to the active preset changes the target
	AST_WRITE_TARGET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(wr_fire && reg_idx == {2'b00, sel_idx})
		|=> (sel_idx != $past(sel_idx)) || (target_code == ($past(pwdata_i[6:0]) & CODE_MASK)))
		else $error("active preset write not applied");

	// Millivolt output matches the code mapping
	AST_MV_MAP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$past(rst_n_i) |-> setpoint_mv_o == BASE_MV + 11'($past(setpoint_q) * LSB_MV))
		else $error("millivolt mapping wrong");

	// Ready for exactly one cycle after setup
	AST_APB_READY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		setup_phase |=> pready_o ##1 !pready_o)
		else $error("APB ready timing wrong");

endmodule

/* File: vprc_step_timer.sv */
// Fractional step timer driven by the ramp rate code
`timescale 1ns/1ps
`include "vprc_defines.svh"
module vprc_step_timer
	import vprc_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic       big_step_i,
	input  wire logic [2:0] rate_code_i,
	output logic            step_o
);

	localparam logic [11:0] INC_FAST  = 12'(`VPRC_RATE_INC_FAST);
	localparam logic [11:0] THR_SMALL = 12'(`VPRC_THR_SMALL);
	localparam logic [11:0] THR_BIG   = 12'(`VPRC_THR_BIG);

	logic [11:0] acc_q;   // Elapsed ramp in 10 uV units
	logic [11:0] acc_sum; // Accumulator plus increment
	logic [11:0] thr;     // Units per step
	logic        step_q;  // Step pulse

	assign acc_sum = acc_q + (INC_FAST >> rate_code_i);
	assign thr     = big_step_i ? THR_BIG : THR_SMALL;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_q  <= 12'h000;
			step_q <= 1'b0;
		end else if (!run_i) begin
			acc_q  <= 12'h000;
			step_q <= 1'b0;
		end else if (acc_sum >= thr) begin
			acc_q  <= acc_sum - thr;
			step_q <= 1'b1;
		end else begin
			acc_q  <= acc_sum;
			step_q <= 1'b0;
		end
	end

	assign step_o = step_q;

	// Fastest code gives a 10 mV step within eight cycles
	AST_FAST_STEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(run_i && rate_code_i == 3'h0 && !big_step_i && acc_q == 12'h000)
		|-> ##[1:8] (step_q || !run_i || rate_code_i != 3'h0 || big_step_i))
		else $error("fast ramp step late");

endmodule
